/* File: design/tpwm_top.sv */
// Behaviour
// - each channel picks PWM or match output
// - mode 00 drives low below match
// - mode 01 drives high below match
// - mode 10 forces output low
// - mode 11 forces output high
// - channel k field at bits 2k+1:2k
// - match hit: none, low, high, toggle
// - channels 4..0 in low ten bits
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
module tpwm_top
  import tpwm_pkg::*;
#(
  parameter int NCH = TPWM_NCH,
  parameter int CNT_W = TPWM_CNT_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // timer counter and match values
  input wire logic [CNT_W-1:0] timer_count_value,
  input wire logic timer_count_strobe,
  input wire logic [NCH-1:0][CNT_W-1:0] channel_match_value,
  // channel outputs
  output logic [NCH-1:0] channel_output_pin
);

  // ==========================================================
  // bus carriers
  tpwm_apb_req_t bus_req;
  tpwm_apb_rsp_t bus_rsp;

  assign bus_req.sel = psel;
  assign bus_req.enable = penable;
  assign bus_req.write = pwrite;
  assign bus_req.addr = paddr;
  assign bus_req.wdata = pwdata;
  assign bus_req.strb = pstrb;

  assign pready = bus_rsp.ready;
  assign prdata = bus_rsp.rdata;
  assign pslverr = bus_rsp.slverr;

  // ==========================================================
  // registers
  logic [31:0] output_mode_select_low;
  logic [31:0] match_pin_action_control;
  logic [NCH-1:0] pwm_enable;
  logic [NCH-1:0] match_level;

  // ==========================================================
  // address decode
  wire hit_mode = paddr == TPWM_OFS_MODE;
  wire hit_action = paddr == TPWM_OFS_ACTION;
  wire hit_enable = paddr == TPWM_OFS_ENABLE;
  wire hit_level = paddr == TPWM_OFS_LEVEL;
  wire hit_status = paddr == TPWM_OFS_STATUS;
  wire addr_hit = hit_mode | hit_action | hit_enable | hit_level | hit_status;

  logic write_pulse;

  wire wr_mode = write_pulse & hit_mode;
  wire wr_action = write_pulse & hit_action;
  wire wr_enable = write_pulse & hit_enable;
  wire wr_level = write_pulse & hit_level;

  // ==========================================================
  // byte lane merge
  function automatic logic [31:0] tpwm_merge(input logic [31:0] old_value,
                                              input logic [31:0] new_value,
                                              input logic [3:0] strb);
    logic [31:0] merged;
    merged = old_value;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merged[8*b +: 8] = new_value[8*b +: 8];
      end
    end
    return merged;
  endfunction : tpwm_merge

  wire [31:0] enable_word = {{(32-NCH){1'b0}}, pwm_enable};
  wire [31:0] level_word = {{(32-NCH){1'b0}}, match_level};
  wire [31:0] status_word = {{(32-NCH){1'b0}}, channel_output_pin};

  wire [31:0] next_mode = tpwm_merge(output_mode_select_low, pwdata, pstrb);
  wire [31:0] next_action = tpwm_merge(match_pin_action_control, pwdata, pstrb);
  wire [31:0] next_enable_word = tpwm_merge(enable_word, pwdata, pstrb);
  wire [31:0] next_level_word = tpwm_merge(level_word, pwdata, pstrb);

  // ==========================================================
  // read mux
  wire [31:0] read_value =
    hit_mode ? output_mode_select_low :
    hit_action ? match_pin_action_control :
    hit_enable ? enable_word :
    hit_level ? level_word :
    hit_status ? status_word : TPWM_RDATA_ZERO;

  // ==========================================================
  // bus slave
  tpwm_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .req(bus_req),
    .rsp(bus_rsp),
    .read_value(read_value),
    .addr_hit(addr_hit),
    .write_pulse(write_pulse)
  );

  // ==========================================================
  // mode register, all sixteen fields read/write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_mode_select_low <= TPWM_RST_MODE;
    end else if (wr_mode) begin
      output_mode_select_low <= next_mode;
    end
  end

  // ==========================================================
  // match action register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_pin_action_control <= TPWM_RST_ACTION;
    end else if (wr_action) begin
      match_pin_action_control <= next_action;
    end
  end

  // ==========================================================
  // pwm or match select per channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_enable <= TPWM_RST_ENABLE[NCH-1:0];
    end else if (wr_enable) begin
      pwm_enable <= next_enable_word[NCH-1:0];
    end
  end

  // ==========================================================
  // channels
  for (genvar k = 0; k < NCH; k++) begin : g_chan
    tpwm_chan_cfg_t cfg;

    // field of channel k at bits 2k+1:2k
    assign cfg.wave_sel = output_mode_select_low[TPWM_FIELD_W*k +: TPWM_FIELD_W];
    assign cfg.match_action = match_pin_action_control[TPWM_FIELD_W*k +: TPWM_FIELD_W];
    assign cfg.pwm_enable = pwm_enable[k];

    tpwm_chan #(
      .CNT_W(CNT_W)
    ) u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg),
      .count(timer_count_value),
      .match(channel_match_value[k]),
      .count_strobe(timer_count_strobe),
      .level_load(wr_level),
      .level_value(next_level_word[k]),
      .match_level(match_level[k]),
      .pin(channel_output_pin[k])
    );
  end

endmodule : tpwm_top

/* File: design/tpwm_pkg.sv */
package tpwm_pkg;

  // ==========================================================
  // sizes
  localparam int TPWM_NCH = 16;
  localparam int TPWM_CNT_W = 16;
  localparam int TPWM_ADDR_W = 12;
  localparam int TPWM_DATA_W = 32;
  localparam int TPWM_FIELD_W = 2;

  // ==========================================================
  // register byte offsets
  localparam logic [11:0] TPWM_OFS_ACTION = 12'h08c;
  localparam logic [11:0] TPWM_OFS_MODE = 12'h094;
  localparam logic [11:0] TPWM_OFS_ENABLE = 12'h0a0;
  localparam logic [11:0] TPWM_OFS_LEVEL = 12'h0a4;
  localparam logic [11:0] TPWM_OFS_STATUS = 12'h0a8;

  // ==========================================================
  // reset values
  localparam logic [31:0] TPWM_RST_ACTION = 32'h0000_0000;
  localparam logic [31:0] TPWM_RST_MODE = 32'h0000_0000;
  localparam logic [15:0] TPWM_RST_ENABLE = 16'h0000;
  localparam logic [15:0] TPWM_RST_LEVEL = 16'h0000;
  localparam logic [31:0] TPWM_RDATA_ZERO = 32'h0000_0000;

  // ==========================================================
  // wave select encodings
  localparam logic [1:0] TPWM_WAVE_MODE1 = 2'h0;
  localparam logic [1:0] TPWM_WAVE_MODE2 = 2'h1;
  localparam logic [1:0] TPWM_WAVE_LOW = 2'h2;
  localparam logic [1:0] TPWM_WAVE_HIGH = 2'h3;

  // ==========================================================
  // match action encodings
  localparam logic [1:0] TPWM_ACT_NONE = 2'h0;
  localparam logic [1:0] TPWM_ACT_LOW = 2'h1;
  localparam logic [1:0] TPWM_ACT_HIGH = 2'h2;
  localparam logic [1:0] TPWM_ACT_TOGGLE = 2'h3;

  // ==========================================================
  // bus carriers and channel configuration
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
  } tpwm_apb_req_t;

  typedef struct packed {
    logic ready;
    logic [31:0] rdata;
    logic slverr;
  } tpwm_apb_rsp_t;

  typedef struct packed {
    logic [1:0] wave_sel;
    logic [1:0] match_action;
    logic pwm_enable;
  } tpwm_chan_cfg_t;

endpackage : tpwm_pkg

/* File: design/tpwm_apb_slave.sv */
`timescale 1ns/1ns
module tpwm_apb_slave
  import tpwm_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bus side
  input wire tpwm_apb_req_t req,
  output tpwm_apb_rsp_t rsp,
  // register file side
  input wire logic [31:0] read_value,
  input wire logic addr_hit,
  output logic write_pulse
);

  // ==========================================================
  // phase decode
  wire setup_phase = req.sel & ~req.enable;
  wire access_phase = req.sel & req.enable;

  logic [31:0] rdata_hold;

  // read data captured in setup, presented in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_hold <= TPWM_RDATA_ZERO;
    end else if (setup_phase) begin
      rdata_hold <= (addr_hit && !req.write) ? read_value : TPWM_RDATA_ZERO;
    end
  end

  // ==========================================================
  // answer: no wait states, error on unmapped address
  assign rsp.ready = access_phase;
  assign rsp.rdata = rdata_hold;
  assign rsp.slverr = access_phase & ~addr_hit;
  assign write_pulse = access_phase & req.write & addr_hit;

endmodule : tpwm_apb_slave

/* File: design/tpwm_chan.sv */
`timescale 1ns/1ns
module tpwm_chan
  import tpwm_pkg::*;
#(
  parameter int CNT_W = TPWM_CNT_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // configuration
  input wire tpwm_chan_cfg_t cfg,
  // timer
  input wire logic [CNT_W-1:0] count,
  input wire logic [CNT_W-1:0] match,
  input wire logic count_strobe,
  // software preset of the match latch
  input wire logic level_load,
  input wire logic level_value,
  // state
  output logic match_level,
  output logic pin
);

  // ==========================================================
  // compare
  wire below = count < match;
  wire hit = count_strobe & (count == match);

  logic pwm_level;
  logic next_match_level;

  always_comb begin
    case (cfg.wave_sel)
      TPWM_WAVE_MODE1: pwm_level = ~below;
      TPWM_WAVE_MODE2: pwm_level = below;
      TPWM_WAVE_LOW: pwm_level = 1'b0;
      TPWM_WAVE_HIGH: pwm_level = 1'b1;
      default: pwm_level = 1'b0;
    endcase
  end

  // ==========================================================
  // match latch; a hit wins over a software preset
  always_comb begin
    next_match_level = level_load ? level_value : match_level;
    if (hit) begin
      case (cfg.match_action)
        TPWM_ACT_NONE: next_match_level = match_level;
        TPWM_ACT_LOW: next_match_level = 1'b0;
        TPWM_ACT_HIGH: next_match_level = 1'b1;
        TPWM_ACT_TOGGLE: next_match_level = ~match_level;
        default: next_match_level = match_level;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_level <= 1'b0;
      pin <= 1'b0;
    end else begin
      match_level <= next_match_level;
      pin <= cfg.pwm_enable ? pwm_level : next_match_level;
    end
  end

endmodule : tpwm_chan

/* File: sim/tpwm_assertions.sv */
`timescale 1ns/1ns
module tpwm_assertions
  import tpwm_pkg::*;
#(
  parameter int NCH = 16,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // timer and outputs
  input wire logic [CNT_W-1:0] timer_count_value,
  input wire logic timer_count_strobe,
  input wire logic [NCH-1:0][CNT_W-1:0] channel_match_value,
  input wire logic [NCH-1:0] channel_output_pin
);
  // ==========================================================
  // register shadows
  logic [31:0] md;
  logic [31:0] act;
  logic [15:0] en;
  wire wr = psel && penable && pwrite;
  wire [31:0] bm = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [CNT_W-1:0] cv = timer_count_value;
  wire [CNT_W-1:0] m15 = channel_match_value[15];
  wire [NCH-1:0] pin = channel_output_pin;
  wire h15 = timer_count_strobe && cv == m15;
  wire h13 = timer_count_strobe && cv == channel_match_value[13];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      md <= '0;
      act <= '0;
      en <= '0;
    end else if (wr) begin
      if (paddr == TPWM_OFS_MODE) md <= (md & ~bm) | (pwdata & bm);
      if (paddr == TPWM_OFS_ACTION) act <= (act & ~bm) | (pwdata & bm);
      if (paddr == TPWM_OFS_ENABLE) en <= (en & ~bm[15:0]) | (pwdata[15:0] & bm[15:0]);
    end
  end
  // ==========================================================
  // properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_mode1; en[15] && md[31:30] == 2'h0 && cv < m15 |=> !pin[15]; endproperty
  a_mode1: assert property (p_mode1) else $error("mode1 not low below match");
  property p_mode2; en[15] && md[31:30] == 2'h1 && cv < m15 |=> pin[15]; endproperty
  a_mode2: assert property (p_mode2) else $error("mode2 not high below match");
  property p_low; en[15] && md[31:30] == 2'h2 |=> !pin[15]; endproperty
  a_low: assert property (p_low) else $error("forced low broken");
  property p_high; en[15] && md[31:30] == 2'h3 |=> pin[15]; endproperty
  a_high: assert property (p_high) else $error("forced high broken");
  property p_past; en[15] && !md[31] && cv >= m15 |=> pin[15] == !$past(md[30]); endproperty
  a_past: assert property (p_past) else $error("level past match wrong");
  property p_ch5; en[5] && md[11:10] == 2'h3 |=> pin[5]; endproperty
  a_ch5: assert property (p_ch5) else $error("channel 5 field misplaced");
  property p_ch0; en[0] && md[1:0] == 2'h2 |=> !pin[0]; endproperty
  a_ch0: assert property (p_ch0) else $error("channel 0 field misplaced");
  property p_act; !en[13] && h13 && act[27:26] == 2'h1 |=> !pin[13]; endproperty
  a_act: assert property (p_act) else $error("match low action broken");
  property p_tog;
    !en[15] && !$past(en[15]) && h15 && act[31:30] == 2'h3 |=> pin[15] != $past(pin[15]);
  endproperty
  a_tog: assert property (p_tog) else $error("match toggle broken");
  c_mode1: cover property (en[15] && md[31:30] == 2'h0 && cv >= m15);
  c_tog: cover property (!en[15] && h15 && act[31:30] == 2'h3);
  c_ch5: cover property (en[5] && md[11:10] == 2'h3);
endmodule : tpwm_assertions

bind tpwm_top tpwm_assertions #(.NCH(NCH), .CNT_W(CNT_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .timer_count_value(timer_count_value),
  .timer_count_strobe(timer_count_strobe), .channel_match_value(channel_match_value),
  .channel_output_pin(channel_output_pin));

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import tpwm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  tpwm_apb_req_t q = '0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic [15:0] cnt = '0;
  logic stb = 1'b0;
  logic [15:0][15:0] mv = '0;
  logic [32:0] expq[$];
  logic [32:0] got;
  wire [15:0] pins;
  int bad_count = 0;
  int samples_checked = 0;
  int seed = 32'hf728;
  int cyc = 0;
  always #5 pclk = ~pclk;
  tpwm_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(q.sel), .penable(q.enable), .pwrite(q.write),
    .paddr(q.addr), .pwdata(q.wdata), .pstrb(q.strb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .timer_count_value(cnt), .timer_count_strobe(stb),
    .channel_match_value(mv), .channel_output_pin(pins));
  // ==========================================================
  // bus and check tasks
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hf);
    q <= '{1'b1, 1'b0, w, a, d, s};
    @(posedge pclk);
    q.enable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q <= '0;
    @(posedge pclk);
  endtask : xfer
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic hit(input logic [15:0] c);
    cnt <= c;
    stb <= 1'b1;
    @(posedge pclk);
    stb <= 1'b0;
    @(posedge pclk);
  endtask : hit
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // read monitor and timeout
  always @(posedge pclk) begin
    cyc++;
    if (q.sel && q.enable && !q.write && pready === 1'b1) begin
      got = expq.pop_front();
      check({pslverr, prdata}, got);
      if (q.addr == TPWM_OFS_STATUS) begin
        check({17'h0, pins}, got);
      end
    end
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] v;
    logic [15:0] c;
    logic [15:0] e;
    logic [15:0][15:0] nm;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(TPWM_OFS_MODE, '0);
    rd(TPWM_OFS_ACTION, '0);
    rd(TPWM_OFS_STATUS, '0);
    rd(12'h000, {1'b1, 32'h0});
    xfer(1'b1, TPWM_OFS_ENABLE, 32'h0000_ffff);
    rd(TPWM_OFS_ENABLE, {17'h0, 16'hffff});
    repeat (24) begin
      v = $random(seed);
      c = 16'($random(seed));
      for (int k = 0; k < 16; k++) begin
        nm[k] = (k % 4 == 0) ? c : (k % 4 == 1) ? c + 16'h1 : 16'($random(seed));
        e[k] = v[2*k+1] ? v[2*k] : ((c >= nm[k]) ^ v[2*k]);
      end
      cnt <= c;
      mv <= nm;
      xfer(1'b1, TPWM_OFS_MODE, v);
      rd(TPWM_OFS_MODE, {1'b0, v});
      rd(TPWM_OFS_STATUS, {17'h0, e});
    end
    xfer(1'b1, TPWM_OFS_ENABLE, 32'h0);
    xfer(1'b1, TPWM_OFS_ACTION, 32'he4e4_e4e4);
    mv <= {16{cnt}};
    hit(cnt);
    rd(TPWM_OFS_STATUS, {17'h0, 16'hcccc});
    hit(cnt);
    rd(TPWM_OFS_STATUS, {17'h0, 16'h4444});
    hit(~cnt);
    rd(TPWM_OFS_STATUS, {17'h0, 16'h4444});
    rd(TPWM_OFS_ENABLE, '0);
    rd(TPWM_OFS_LEVEL, {17'h0, 16'h4444});
    xfer(1'b1, TPWM_OFS_LEVEL, 32'h0000_a5a5);
    rd(TPWM_OFS_STATUS, {17'h0, 16'ha5a5});
    xfer(1'b1, TPWM_OFS_STATUS, 32'h0000_ffff);
    rd(TPWM_OFS_STATUS, {17'h0, 16'ha5a5});
    xfer(1'b1, TPWM_OFS_MODE, 32'h0, 4'h2);
    rd(TPWM_OFS_MODE, {1'b0, v[31:16], 8'h00, v[7:0]});
    report_and_stop();
  end
endmodule : tb_top
